// [core/ulsl_pkg.sv]
// Shared constants and types for the line status logic
package ulsl_pkg;
   // ----------------------------------------------------------------
   // Register offsets (8-bit address space)
   // ----------------------------------------------------------------
   localparam logic [7:0] RBR_OFS  = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h03;
   localparam logic [7:0] LSR_OFS  = 8'h05;
   // ----------------------------------------------------------------
   // Status bit positions
   // ----------------------------------------------------------------
   localparam int LSR_AVAIL = 0;
   localparam int LSR_OE    = 1;
   localparam int LSR_PAR   = 2;
   localparam int LSR_FRM   = 3;
   localparam int LSR_BRK   = 4;
   localparam int LSR_HOLD  = 5;
   localparam int LSR_ALLE  = 6;
   localparam int LSR_ERR   = 7;
   localparam logic [7:0] LSR_RST = 8'h60;
   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_CHAR_LSB = 0;
   localparam int CTRL_STOP2    = 2;
   localparam int CTRL_PEN      = 3;
   localparam int CTRL_EPS      = 4;
   localparam int CTRL_BRK      = 6;
   localparam int CTRL_FEN      = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int FIFO_DEPTH = 32;
   localparam int ENTRY_W    = 11;
   localparam logic [3:0] LEN_BASE = 4'h5;
   typedef struct packed {
      logic       brk;
      logic       frm;
      logic       par;
      logic [7:0] data;
   } ulsl_entry_t;
   typedef enum logic [1:0] {
      BRK_IDLE  = 2'b00,
      BRK_COUNT = 2'b01,
      BRK_HELD  = 2'b11
   } ulsl_brk_t;
endpackage

// [core/ulsl_top.sv]
// Line status logic with its receive FIFO
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Parameterised FIFO, valid/ready on both sides
// ----------------------------------------------------------------
module ulsl_fifo #(
   parameter int W     = 11,
   parameter int DEPTH = 32
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   flush,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic [W-1:0]           in_data,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic [W-1:0]                out_data,
   output logic [$clog2(DEPTH):0]      count
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   wire           push = in_valid & in_ready;
   wire           pop  = out_valid & out_ready;
   // Honest full/empty straight from the occupancy count
   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rp_q];
   assign count     = cnt_q;
   // Storage has no reset; only pointers and count need a defined value
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end
   // Pointer and count update
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_q + AW'(push);
         rp_q  <= rp_q + AW'(pop);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// Functional notes
// - Error summary reads zero whenever the receive FIFO is disabled.
// - With FIFO on, summary sets while any stored entry carries an error.
// - Summary clears on a status read only if no errored entry remains.
// - All-empty is one only with holding, shifter empty and transmitter idle.
// - Holding-empty is zero while the holding FIFO has data or a break is sent, else one.
// - Neither transmit empty flag sets while a break is being sent.
// - Break flag sets when the line stays low beyond one character time.
// - Status read clears break, framing, parity and overrun flags.
// - With FIFO on, a break loads one zero character marked framing error.
// - Break framing error is shown only when that entry reaches the head.
// - Framing flag sets for head character whose stop bit was zero.
// - Parity flag sets for head character received with wrong parity.
// - Without FIFO, overrun sets when unread buffer gets a new character.
// - With FIFO full, overrun sets and the new character is dropped.
// - Data-available sets when a character enters the buffer or FIFO.
// - Data-available clears on buffer read or when the FIFO empties.
// - With parity on, every received character is parity checked.
module ulsl_top (
   input  wire logic       REF_CLK,
   input  wire logic       SYS_RST,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR_STB,
   input  wire logic       RD_STB,
   output logic [7:0]      RDATA,
   input  wire logic       RXD,
   input  wire logic       BAUD_TICK,
   input  wire logic       RX_CHAR_DONE,
   input  wire logic [7:0] RX_CHAR_DATA,
   input  wire logic       RX_PAR_BIT,
   input  wire logic       RX_STOP_BIT,
   output logic            RX_FIFO_READY,
   input  wire logic       TX_HOLD_EMPTY_IN,
   input  wire logic       TX_SHIFT_EMPTY,
   input  wire logic       TX_IDLE,
   output logic [7:0]      LINE_CTRL,
   output logic            TX_HOLD_EMPTY,
   output logic            TX_ALL_EMPTY
);
   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   logic [7:0]   ctrl_q;
   logic [7:0]   rdata_q;
   wire          rbr_rd  = RD_STB & (ADDR == ulsl_pkg::RBR_OFS);
   wire          lsr_rd  = RD_STB & (ADDR == ulsl_pkg::LSR_OFS);
   wire          ctrl_rd = RD_STB & (ADDR == ulsl_pkg::CTRL_OFS);
   // Status address has no write decode at all
   wire          ctrl_wr = WR_STB & (ADDR == ulsl_pkg::CTRL_OFS);
   wire          fen     = ctrl_q[ulsl_pkg::CTRL_FEN];
   wire          pen     = ctrl_q[ulsl_pkg::CTRL_PEN];
   wire          brk_cmd = ctrl_q[ulsl_pkg::CTRL_BRK];
   wire [1:0]    len_sel = ctrl_q[ulsl_pkg::CTRL_CHAR_LSB +: 2];
   // Switching FIFO mode discards stale entries from the old mode
   wire          flush   = ctrl_wr & (WDATA[ulsl_pkg::CTRL_FEN] != fen);
   // Next control bits, so mode and break gates act in the write cycle itself
   wire          fen_nx  = ctrl_wr ? WDATA[ulsl_pkg::CTRL_FEN] : fen;
   wire          brk_nx  = ctrl_wr ? WDATA[ulsl_pkg::CTRL_BRK] : brk_cmd;

   // ----------------------------------------------------------------
   // Break detector: counts bit times while the line is low
   // ----------------------------------------------------------------
   ulsl_pkg::ulsl_brk_t brk_st_q;
   ulsl_pkg::ulsl_brk_t brk_st_d;
   logic [3:0]   brk_cnt_q;
   // Start + data + parity + stop bits of the programmed format
   wire  [3:0]   char_bits = 4'h1 + ulsl_pkg::LEN_BASE + {2'h0, len_sel}
                           + {3'h0, pen} + {3'h0, ctrl_q[ulsl_pkg::CTRL_STOP2]} + 4'h1;
   wire          brk_fire  = (brk_st_q == ulsl_pkg::BRK_COUNT) & !RXD & BAUD_TICK
                           & (brk_cnt_q >= char_bits);
   // Next state; HELD waits for the line to rise so one break loads once
   always_comb begin
      brk_st_d = brk_st_q;
      case (brk_st_q)
         ulsl_pkg::BRK_IDLE: begin
            if (!RXD) brk_st_d = ulsl_pkg::BRK_COUNT;
         end
         ulsl_pkg::BRK_COUNT: begin
            if (RXD) brk_st_d = ulsl_pkg::BRK_IDLE;
            else if (brk_fire) brk_st_d = ulsl_pkg::BRK_HELD;
         end
         ulsl_pkg::BRK_HELD: begin
            if (RXD) brk_st_d = ulsl_pkg::BRK_IDLE;
         end
         default: brk_st_d = ulsl_pkg::BRK_IDLE;
      endcase
   end
   // State and bit-time counter
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         brk_st_q  <= ulsl_pkg::BRK_IDLE;
         brk_cnt_q <= 4'h0;
      end else begin
         brk_st_q  <= brk_st_d;
         if (brk_st_q != ulsl_pkg::BRK_COUNT) brk_cnt_q <= 4'h0;
         else if (BAUD_TICK && brk_cnt_q != 4'hf) brk_cnt_q <= brk_cnt_q + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Received entry build, parity check
   // ----------------------------------------------------------------
   ulsl_pkg::ulsl_entry_t char_ent;
   ulsl_pkg::ulsl_entry_t new_ent;
   // Mask off bits above the programmed character length
   wire  [7:0]   len_mask  = 8'hff >> (2'h3 - len_sel);
   wire          par_sum   = ^(RX_CHAR_DATA & len_mask) ^ RX_PAR_BIT;
   // Even select wants an even total of ones
   wire          par_bad   = pen & (par_sum ^ !ctrl_q[ulsl_pkg::CTRL_EPS]);
   assign char_ent.brk  = 1'b0;
   assign char_ent.frm  = !RX_STOP_BIT;
   assign char_ent.par  = par_bad;
   assign char_ent.data = RX_CHAR_DATA & len_mask;
   // Break wins over a character flagged in the same cycle
   assign new_ent = brk_fire ? ulsl_pkg::ulsl_entry_t'{brk: 1'b1, frm: 1'b1, par: 1'b0,
                                                       data: 8'h00} : char_ent;
   wire          push_ev   = RX_CHAR_DONE | brk_fire;

   // ----------------------------------------------------------------
   // Receive FIFO and single buffer
   // ----------------------------------------------------------------
   logic                  f_in_ready;
   logic                  f_out_valid;
   logic [10:0]           f_out_raw;
   logic [5:0]            f_count;
   ulsl_pkg::ulsl_entry_t rbuf_q;
   logic                  rbuf_vld_q;
   wire                   f_in_valid = fen & push_ev;
   wire                   f_push     = f_in_valid & f_in_ready;
   // Entries carry their own status bits
   ulsl_fifo #(
      .W     (ulsl_pkg::ENTRY_W),
      .DEPTH (ulsl_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .clk       (REF_CLK),
      .rst       (SYS_RST),
      .flush     (flush),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (new_ent),
      .out_valid (f_out_valid),
      .out_ready (fen & rbr_rd),
      .out_data  (f_out_raw),
      .count     (f_count)
   );
   // Head of whichever store the mode selects
   ulsl_pkg::ulsl_entry_t head;
   assign head = fen ? ulsl_pkg::ulsl_entry_t'(f_out_raw) : rbuf_q;
   wire          head_valid = fen ? f_out_valid : rbuf_vld_q;
   wire          pop        = rbr_rd & head_valid;
   wire          head_err   = head.par | head.frm | head.brk;
   wire          ent_err    = new_ent.par | new_ent.frm | new_ent.brk;
   // A new head appears after a push into empty or a pop with more behind
   wire          fresh_d    = fen ? ((f_push & !f_out_valid)
                                  | (pop & ((f_count > 6'h01) | f_push)))
                                  : push_ev;
   // Overrun per mode: unread buffer, or FIFO full with the char dropped
   wire          oe_set     = push_ev & (fen ? !f_in_ready : (rbuf_vld_q & !pop));
   // Ready leaves a flop; its next value follows the FIFO's own count update
   wire  [5:0]   f_count_nx = f_count + {5'h00, f_push} - {5'h00, fen & pop};
   logic         rx_rdy_q;
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rx_rdy_q <= 1'b1;
      end else begin
         rx_rdy_q <= flush | (f_count_nx != 6'(ulsl_pkg::FIFO_DEPTH));
      end
   end
   // Single buffer used while the FIFO is off
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rbuf_q     <= '0;
         rbuf_vld_q <= 1'b0;
      end else if (fen || flush) begin
         rbuf_vld_q <= 1'b0;
      end else if (push_ev) begin
         rbuf_q     <= new_ent;
         rbuf_vld_q <= 1'b1;
      end else if (pop) begin
         rbuf_vld_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Receive flags; a set in the clearing cycle wins
   // ----------------------------------------------------------------
   logic         fresh_q;
   logic         oe_q;
   logic         par_q;
   logic         frm_q;
   logic         lbrk_q;
   logic         err_q;
   logic [5:0]   err_cnt_q;
   wire          head_new  = fresh_q & head_valid;
   wire          err_inc   = f_push & ent_err;
   wire          err_dec   = fen & pop & head_err;
   // Errored entries still in the FIFO, including the head
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         err_cnt_q <= 6'h00;
      end else if (flush || !fen) begin
         err_cnt_q <= 6'h00;
      end else begin
         err_cnt_q <= err_cnt_q + {5'h00, err_inc} - {5'h00, err_dec};
      end
   end
   // Head flags only pick up an entry's status when it reaches the top
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         fresh_q <= 1'b0;
         oe_q    <= 1'b0;
         par_q   <= 1'b0;
         frm_q   <= 1'b0;
         lbrk_q  <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         fresh_q <= fresh_d;
         oe_q    <= oe_set | (oe_q & !lsr_rd);
         par_q   <= (head_new & head.par) | (par_q & !lsr_rd);
         frm_q   <= (head_new & head.frm) | (frm_q & !lsr_rd);
         lbrk_q  <= (head_new & head.brk) | (lbrk_q & !lsr_rd);
         err_q   <= fen_nx & ((err_cnt_q != 6'h00)
                    | (err_q & !lsr_rd));
      end
   end

   // ----------------------------------------------------------------
   // Transmit flags, held low while a break is sent
   // ----------------------------------------------------------------
   logic         hold_empty_q;
   logic         all_empty_q;
   // Gated by the next break bit so no flag slips out in the write cycle
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         hold_empty_q <= ulsl_pkg::LSR_RST[ulsl_pkg::LSR_HOLD];
         all_empty_q  <= ulsl_pkg::LSR_RST[ulsl_pkg::LSR_ALLE];
      end else begin
         hold_empty_q <= TX_HOLD_EMPTY_IN & !brk_nx;
         all_empty_q  <= TX_HOLD_EMPTY_IN & TX_SHIFT_EMPTY & TX_IDLE & !brk_nx;
      end
   end

   // ----------------------------------------------------------------
   // Read data and control register
   // ----------------------------------------------------------------
   wire  [7:0]   lsr_val = {err_q, all_empty_q, hold_empty_q, lbrk_q, frm_q, par_q, oe_q,
                            head_valid};
   // Unmapped reads return zero; data stands for one cycle only
   wire  [7:0]   rd_mux  = lsr_rd  ? lsr_val
                         : ctrl_rd ? ctrl_q
                         : (rbr_rd & head_valid) ? head.data
                         : 8'h00;
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ctrl_q  <= ulsl_pkg::CTRL_RST;
         rdata_q <= 8'h00;
      end else begin
         if (ctrl_wr) ctrl_q <= WDATA;
         rdata_q <= RD_STB ? rd_mux : 8'h00;
      end
   end
   // Every output comes straight from its flop
   assign RDATA         = rdata_q;
   assign LINE_CTRL     = ctrl_q;
   assign TX_HOLD_EMPTY = hold_empty_q;
   assign TX_ALL_EMPTY  = all_empty_q;
   assign RX_FIFO_READY = rx_rdy_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   a_err_fifo_off: assert property (!fen |=> !err_q)
      else $error("summary set with FIFO off");
   a_err_off_now: assert property (!fen |-> !err_q)
      else $error("summary shown with FIFO off");
   a_err_sets: assert property (fen_nx && err_cnt_q != 6'h00 |=> err_q)
      else $error("summary missed errored entry");
   a_err_holds: assert property (err_q && fen_nx && !(lsr_rd && err_cnt_q == 6'h00)
                                 |=> err_q)
      else $error("summary cleared early");
   a_all_empty_cause: assert property (!(TX_HOLD_EMPTY_IN && TX_SHIFT_EMPTY && TX_IDLE)
                                       |=> !TX_ALL_EMPTY)
      else $error("all-empty with busy transmitter");
   a_hold_empty_data: assert property (!TX_HOLD_EMPTY_IN |=> !TX_HOLD_EMPTY)
      else $error("holding-empty with data");
   a_brk_blocks: assert property (brk_cmd |-> !TX_HOLD_EMPTY && !TX_ALL_EMPTY)
      else $error("empty flag during break");
   a_brk_once: assert property (brk_fire |=> !brk_fire [*4])
      else $error("break loaded twice");
   a_lsr_clear: assert property (lsr_rd && !fresh_q && !oe_set
                                 |=> !lbrk_q && !frm_q && !par_q && !oe_q)
      else $error("status read left a flag");
   a_oe_drop: assert property (fen && push_ev && !f_in_ready && !pop && !flush
                               |=> oe_q && f_count == $past(f_count))
      else $error("full FIFO stored or no overrun");
   a_oe_buffer: assert property (!fen && push_ev && rbuf_vld_q && !pop && !flush
                                 |=> oe_q)
      else $error("buffer overrun not flagged");
   a_ready_reg: assert property (RX_FIFO_READY == f_in_ready)
      else $error("ready flag off the FIFO count");
   a_dr_sets: assert property (push_ev && (fen ? f_in_ready : 1'b1) && !flush
                               |=> head_valid)
      else $error("data available missed");
   a_dr_buf_clear: assert property (!fen && pop && !push_ev && !flush |=> !head_valid)
      else $error("data available stuck after read");
   a_dr_fifo_clear: assert property (fen && pop && f_count == 6'h01 && !f_push && !flush
                                     |=> !head_valid)
      else $error("data available after last byte");
   a_head_frame: assert property (fresh_q && head_valid && head.frm |=> frm_q)
      else $error("head framing fault lost");
   a_head_par: assert property (fresh_q && head_valid && head.par |=> par_q)
      else $error("head parity fault lost");
   a_head_brk: assert property (fresh_q && head_valid && head.brk |=> lbrk_q)
      else $error("head break flag lost");
   c_brk_fifo: cover property (brk_fire && fen ##[1:40] frm_q && lbrk_q);
   c_overrun: cover property (fen && oe_set);
   c_err_clear: cover property (err_q ##1 lsr_rd ##1 !err_q);
   c_fifo_full: cover property (fen && !RX_FIFO_READY);
endmodule

// [verification/ulsl_remote.sv]
// Remote serial device model feeding the receive side of the line status logic
`timescale 1ns/1ns
module ulsl_remote (
   input  wire logic       clk,
   output logic            rxd,
   output logic            baud_tick,
   output logic            char_done,
   output logic [7:0]      char_data,
   output logic            par_bit,
   output logic            stop_bit
);
   logic [1:0] div_q = 2'h0;
   // ----------------------------------------------------------------
   // Line idle state
   // ----------------------------------------------------------------
   initial begin
      rxd       = 1'b1;
      char_done = 1'b0;
      char_data = 8'h00;
      par_bit   = 1'b0;
      stop_bit  = 1'b1;
   end
   // Bit time of four clocks keeps the break wait short
   always @(posedge clk) begin
      div_q     <= div_q + 2'h1;
      baud_tick <= (div_q == 2'h3);
   end
   // ----------------------------------------------------------------
   // Requests
   // ----------------------------------------------------------------
   // Side lines flip after the pulse so a stale value never looks valid
   task automatic send_char(input logic [7:0] d, input logic p, input logic s);
      @(posedge clk);
      char_done <= 1'b1;
      char_data <= d;
      par_bit   <= p;
      stop_bit  <= s;
      @(posedge clk);
      char_done <= 1'b0;
      char_data <= ~d;
      par_bit   <= ~p;
      stop_bit  <= ~s;
   endtask
   // Line held low for a number of bit times
   task automatic send_break(input int ticks);
      @(posedge clk);
      rxd <= 1'b0;
      repeat (ticks * 4) @(posedge clk);
      rxd <= 1'b1;
   endtask
endmodule

// [verification/tb_uart_line_status_logic.sv]
// Self-checking bench for the line status logic
`timescale 1ns/1ns
module tb_uart_line_status_logic;
   logic        REF_CLK = 1'b0, SYS_RST = 1'b1, WR_STB = 1'b0, RD_STB = 1'b0;
   logic [7:0]  ADDR = 8'h00, WDATA = 8'h00, RDATA, LINE_CTRL, RX_CHAR_DATA;
   logic        RXD, BAUD_TICK, RX_CHAR_DONE, RX_PAR_BIT, RX_STOP_BIT, RX_FIFO_READY;
   logic        TX_HOLD_EMPTY_IN = 1'b1, TX_SHIFT_EMPTY = 1'b1, TX_IDLE = 1'b1;
   logic        TX_HOLD_EMPTY, TX_ALL_EMPTY;
   int          error_cnt = 0, comparisons = 0, cyc = 0;
   logic [31:0] seed = 32'h685a;
   logic [7:0]  ctrl = 8'h00, d;
   logic        m_oe = 0, m_par = 0, m_frm = 0, m_brk = 0, m_hold = 0;
   ulsl_pkg::ulsl_entry_t q[$];
   ulsl_pkg::ulsl_entry_t brk_e = '{brk: 1'b1, frm: 1'b1, par: 1'b0, data: 8'h00};

   always #5 REF_CLK = ~REF_CLK;

   ulsl_top u_ulsl_top (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
      .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .RXD(RXD), .BAUD_TICK(BAUD_TICK),
      .RX_CHAR_DONE(RX_CHAR_DONE), .RX_CHAR_DATA(RX_CHAR_DATA), .RX_PAR_BIT(RX_PAR_BIT),
      .RX_STOP_BIT(RX_STOP_BIT), .RX_FIFO_READY(RX_FIFO_READY),
      .TX_HOLD_EMPTY_IN(TX_HOLD_EMPTY_IN), .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .TX_IDLE(TX_IDLE),
      .LINE_CTRL(LINE_CTRL), .TX_HOLD_EMPTY(TX_HOLD_EMPTY), .TX_ALL_EMPTY(TX_ALL_EMPTY));
   ulsl_remote u_ulsl_remote (.clk(REF_CLK), .rxd(RXD), .baud_tick(BAUD_TICK),
      .char_done(RX_CHAR_DONE), .char_data(RX_CHAR_DATA), .par_bit(RX_PAR_BIT),
      .stop_bit(RX_STOP_BIT));
   // ----------------------------------------------------------------
   // Reference model
   // ----------------------------------------------------------------
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic int n_err();
      int n = 0;
      foreach (q[i]) if (q[i].par | q[i].frm | q[i].brk) n++;
      return n;
   endfunction
   // Break command masks both transmit flags
   function automatic logic [7:0] exp_st();
      logic hold;
      hold = TX_HOLD_EMPTY_IN & ~ctrl[6];
      return {ctrl[7] & ((n_err() > 0) | m_hold), hold & TX_SHIFT_EMPTY & TX_IDLE, hold,
              m_brk, m_frm, m_par, m_oe, q.size() > 0};
   endfunction
   task automatic load(input ulsl_pkg::ulsl_entry_t e);
      m_par |= e.par;
      m_frm |= e.frm;
      m_brk |= e.brk;
   endtask
   // Full FIFO drops the newcomer; without FIFO the single buffer is overwritten
   task automatic push(input ulsl_pkg::ulsl_entry_t e);
      if (ctrl[7] && q.size() == ulsl_pkg::FIFO_DEPTH) m_oe = 1'b1;
      else begin
         if (!ctrl[7] && q.size() > 0) begin
            m_oe = 1'b1;
            void'(q.pop_front());
         end
         if (q.size() == 0) load(e);
         q.push_back(e);
         if (ctrl[7] && (e.par | e.frm | e.brk)) m_hold = 1'b1;
      end
   endtask
   // ----------------------------------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge REF_CLK);
      ADDR   <= a;
      WDATA  <= v;
      WR_STB <= 1'b1;
      @(posedge REF_CLK);
      WR_STB <= 1'b0;
      // A mode change flushes the store and with it any held summary
      if (a == ulsl_pkg::CTRL_OFS && v[7] != ctrl[7]) begin
         q.delete();
         m_hold = 1'b0;
      end
      if (a == ulsl_pkg::CTRL_OFS) ctrl = v;
      repeat (3) @(posedge REF_CLK);
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge REF_CLK);
      ADDR   <= a;
      RD_STB <= 1'b1;
      @(posedge REF_CLK);
      RD_STB <= 1'b0;
      #1 v = RDATA;
      repeat (3) @(posedge REF_CLK);
   endtask
   task automatic chk_st();
      logic [7:0] e, v;
      e = exp_st();
      rd(ulsl_pkg::LSR_OFS, v);
      check(v, e);
      {m_oe, m_par, m_frm, m_brk} = 4'h0;
      if (n_err() == 0) m_hold = 1'b0;
   endtask
   task automatic chk_dat();
      logic [7:0] e, v;
      e = (q.size() > 0) ? q[0].data : 8'h00;
      rd(ulsl_pkg::RBR_OFS, v);
      if (q.size() > 0) void'(q.pop_front());
      if (q.size() > 0) load(q[0]);
      check(v, e);
   endtask
   task automatic rx(input logic [7:0] dv, input logic bad_par, input logic stop);
      ulsl_pkg::ulsl_entry_t e;
      logic good;
      good = ctrl[4] ? ^dv : ~^dv;
      e = '{brk: 1'b0, frm: ~stop, par: ctrl[3] & bad_par, data: dv};
      u_ulsl_remote.send_char(dv, good ^ bad_par, stop);
      push(e);
      repeat (3) @(posedge REF_CLK);
   endtask
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Hang guard well above the fewer than a thousand cycles the run needs
   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == 10000) begin
         error_cnt++;
         test_done();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      chk_st();
      wr(ulsl_pkg::LSR_OFS, 8'h9f);
      chk_st();
      wr(ulsl_pkg::CTRL_OFS, 8'h1b);
      check(LINE_CTRL, 8'h1b);
      rx(rnd(), 1'b0, 1'b0);
      chk_st();
      chk_dat();
      rx(rnd(), 1'b0, 1'b1);
      rx(rnd(), 1'b0, 1'b1);
      chk_st();
      chk_st();
      chk_dat();
      chk_st();
      wr(ulsl_pkg::CTRL_OFS, 8'h9b);
      rx(rnd(), 1'b0, 1'b1);
      rx(rnd(), 1'b1, 1'b1);
      rx(rnd(), 1'b0, 1'b0);
      chk_st();
      chk_dat();
      chk_st();
      chk_dat();
      chk_st();
      chk_dat();
      chk_st();
      chk_st();
      // Break held well past one character time must still load a single entry
      u_ulsl_remote.send_break(20);
      push(brk_e);
      repeat (4) @(posedge REF_CLK);
      chk_st();
      chk_dat();
      chk_st();
      for (int i = 0; i < ulsl_pkg::FIFO_DEPTH; i++) rx(rnd(), 1'b0, 1'b1);
      check({7'h00, RX_FIFO_READY}, 8'h00);
      rx(rnd(), 1'b0, 1'b1);
      chk_st();
      for (int i = 0; i < ulsl_pkg::FIFO_DEPTH; i++) chk_dat();
      chk_st();
      rd(8'h40, d);
      check(d, 8'h00);
      // Every transmit input mix, with and without break being sent
      for (int i = 0; i < 16; i++) begin
         TX_HOLD_EMPTY_IN <= i[0];
         TX_SHIFT_EMPTY   <= i[1];
         TX_IDLE          <= i[2];
         wr(ulsl_pkg::CTRL_OFS, {1'b1, i[3], 6'h1b});
         d = exp_st();
         check({6'h00, TX_ALL_EMPTY, TX_HOLD_EMPTY}, {6'h00, d[6:5]});
         chk_st();
      end
      test_done();
   end
endmodule
